// *** core/li_ion_charge_sequencer.sv ***
/*
   li_ion_charge_sequencer: charge phase control with APB configuration.
   Assumes comparator results synchronous to clk; analog loop outside.
*/
// Design decisions made here: the placing of the registers and the APB slave port.
// Contract
// - start pre-qualification only with supply in limits and adaptor good
// - command reduced safe current during pre-qualification
// - go to constant current when battery exceeds qualification level
// - adaptor source uses default current that software may overwrite
// - usb source starts constant current at the low 100 mA level
// - start safety timer on entry to constant current
// - terminate charge if timer expires in constant current
// - move to constant voltage when regulation voltage is reached
// - flag end of charge when current drops below selected threshold
// - end of charge threshold selectable among three fractions
// - after end of charge, enter maintenance and watch battery
// - restart from maintenance on 200 mV drop if source still valid
// - stop charging when battery temperature is out of range
// - power-up loads default current, voltage and threshold settings
// - usb with current select low raises current to higher level
// - temperature recovery restarts sequence and resets safety timer
// - disable charger whenever enable input is low
`timescale 1ns/10ps
module li_ion_charge_sequencer
   import charge_seq_pkg::*;
#(
   parameter int TICK_COUNT   = TICK_CYCLES,
   parameter int SAFETY_COUNT = SAFETY_TICKS
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // supply and pins
   input  wire logic        supply_in_limits,
   input  wire logic        adaptor_good,
   input  wire logic        source_is_adaptor,
   input  wire logic        usb_current_level_select,
   input  wire logic        charger_enable,
   // battery comparators
   input  wire logic        battery_above_qual,
   input  wire logic        battery_at_regulation,
   input  wire logic [2:0]  current_below_eoc,
   input  wire logic        battery_below_restart,
   input  wire logic        temp_in_range,
   // outputs
   output logic [3:0]       charge_current,
   output logic             prequal_current,
   output logic             charge_on,
   output logic             vreg_high,
   output logic             end_of_charge,
   output logic             fault,
   output charge_state_t    phase
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   charge_state_t state;
   charge_state_t next_state;
   charge_cfg_t   cfg;
   logic          eoc_flag;
   logic          expired_flag;
   logic [31:0]   prescale;
   logic [31:0]   safety;
   logic [3:0]    next_current;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire logic access     = psel && penable;
   wire logic hit_ctrl   = paddr == CTRL_OFFSET;
   wire logic hit_config = paddr == CONFIG_OFFSET;
   wire logic hit_status = paddr == STATUS_OFFSET;
   wire logic mapped     = hit_ctrl || hit_config || hit_status;
   wire logic wr_config  = access && pwrite && hit_config;
   wire logic wr_ctrl    = access && pwrite && hit_ctrl;
   wire logic clear_req  = wr_ctrl && pwdata[CTRL_CLEAR_BIT];

   wire logic [31:0] config_word = {22'h000000,
                                    cfg.eoc_sel,
                                    3'h0,
                                    cfg.vreg_high,
                                    cfg.current};
   wire logic [31:0] status_word = {24'h000000,
                                    expired_flag,
                                    eoc_flag,
                                    fault,
                                    charge_on,
                                    1'b0,
                                    state};
   wire logic [31:0] read_word   = hit_config ? config_word :
                                   hit_status ? status_word :
                                   32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // ------------------------------------------------------------
   // condition decode
   // ------------------------------------------------------------
   wire logic source_valid = supply_in_limits && adaptor_good;
   wire logic run_ok       = source_valid && charger_enable;
   wire logic [1:0] eoc_idx = (cfg.eoc_sel > 2'h2) ? 2'h2 : cfg.eoc_sel;
   wire logic eoc_hit      = current_below_eoc[eoc_idx];
   wire logic tick         = prescale >= 32'(TICK_COUNT - 1);
   wire logic timer_done   = safety >= 32'(SAFETY_COUNT);

   // ------------------------------------------------------------
   // current selection
   // ------------------------------------------------------------
   always_comb
   begin
      if (source_is_adaptor)
         next_current = cfg.current;
      else if (!usb_current_level_select)
         next_current = cfg.current;
      else
         next_current = CURRENT_100MA;
   end

   // ------------------------------------------------------------
   // phase sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_OFF:
            if (run_ok)
               next_state = ST_PREQUAL;
         ST_PREQUAL:
            if (battery_above_qual)
               next_state = ST_CC;
         ST_CC:
            if (timer_done)
               next_state = ST_FAULT;
            else if (battery_at_regulation)
               next_state = ST_CV;
         ST_CV:
            if (eoc_hit)
               next_state = ST_MAINT;
         ST_MAINT:
            if (battery_below_restart)
               next_state = ST_PREQUAL;
         ST_FAULT:
            next_state = ST_FAULT;
         ST_TEMP:
            if (temp_in_range)
               next_state = ST_PREQUAL;
         default:
            next_state = ST_OFF;
      endcase
      if (!run_ok)
         next_state = ST_OFF;
      else if (!temp_in_range && state != ST_FAULT)
         next_state = ST_TEMP;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cfg.current   <= CURRENT_RESET;
         cfg.vreg_high <= VREG_RESET;
         cfg.eoc_sel   <= EOC_RESET;
      end
      else if (wr_config)
      begin
         cfg.current   <= pwdata[CFG_CURRENT_MSB:CFG_CURRENT_LSB];
         cfg.vreg_high <= pwdata[CFG_VREG_BIT];
         cfg.eoc_sel   <= pwdata[CFG_EOC_MSB:CFG_EOC_LSB];
      end
   end

   // ------------------------------------------------------------
   // prescaler and safety timer
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset || next_state == ST_PREQUAL && state != ST_PREQUAL)
         prescale <= 32'h00000000;
      else if (tick)
         prescale <= 32'h00000000;
      else
         prescale <= prescale + 32'h00000001;
   end

   always_ff @(posedge clk)
   begin
      if (reset || state != ST_CC)
         safety <= 32'h00000000;
      else if (tick && !timer_done)
         safety <= safety + 32'h00000001;
   end

   // ------------------------------------------------------------
   // sticky status, set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         eoc_flag     <= 1'b0;
         expired_flag <= 1'b0;
      end
      else
      begin
         if (state == ST_CV && eoc_hit)
            eoc_flag <= 1'b1;
         else if (clear_req || state == ST_PREQUAL)
            eoc_flag <= 1'b0;
         if (state == ST_CC && timer_done)
            expired_flag <= 1'b1;
         else if (clear_req)
            expired_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prdata          <= 32'h00000000;
         charge_current  <= CURRENT_OFF;
         prequal_current <= 1'b0;
         charge_on       <= 1'b0;
         vreg_high       <= VREG_RESET;
         end_of_charge   <= 1'b0;
         fault           <= 1'b0;
         phase           <= ST_OFF;
      end
      else
      begin
         if (psel && !penable && !pwrite)
            prdata <= read_word;
         charge_current  <= (next_state == ST_CC || next_state == ST_CV) ?
                            next_current : CURRENT_OFF;
         prequal_current <= next_state == ST_PREQUAL;
         charge_on       <= next_state == ST_PREQUAL ||
                            next_state == ST_CC ||
                            next_state == ST_CV;
         vreg_high       <= cfg.vreg_high;
         end_of_charge   <= next_state == ST_MAINT;
         fault           <= next_state == ST_FAULT ||
                            next_state == ST_TEMP;
         phase           <= next_state;
      end
   end

endmodule : li_ion_charge_sequencer

// *** core/charge_seq_pkg.sv ***
/*
   charge_seq_pkg: constants and types for the charge sequencer.
   Assumes a 100 MHz clock and a 32-bit APB register bus.
*/
package charge_seq_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] CONFIG_OFFSET = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CFG_CURRENT_LSB = 0;
   localparam int CFG_CURRENT_MSB = 3;
   localparam int CFG_VREG_BIT    = 4;
   localparam int CFG_EOC_LSB     = 8;
   localparam int CFG_EOC_MSB     = 9;
   localparam int CTRL_CLEAR_BIT  = 0;

   // ------------------------------------------------------------
   // current codes: 100 mA + 50 mA per step
   // ------------------------------------------------------------
   localparam logic [3:0] CURRENT_100MA = 4'h0;
   localparam logic [3:0] CURRENT_500MA = 4'h8;
   localparam logic [3:0] CURRENT_OFF   = 4'hF;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0] CURRENT_RESET = CURRENT_500MA;
   localparam logic       VREG_RESET    = 1'b1;
   localparam logic [1:0] EOC_RESET     = 2'h0;

   // ------------------------------------------------------------
   // timing: safety timer 5.6 hr, prescaler 1 ms tick
   // ------------------------------------------------------------
   localparam int  SAFETY_TIME_MIN = 336;
   localparam int  CLK_MHZ         = 100;
   localparam int  TICK_TIME_US    = 1000;
   localparam int  TICK_CYCLES     = TICK_TIME_US * CLK_MHZ;
   localparam int  SAFETY_TICKS    = SAFETY_TIME_MIN * 60 * 1000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_PREQUAL = 3'b001,
      ST_CC      = 3'b010,
      ST_CV      = 3'b011,
      ST_MAINT   = 3'b100,
      ST_FAULT   = 3'b101,
      ST_TEMP    = 3'b110
   } charge_state_t;

   typedef struct packed {
      logic [3:0] current;
      logic       vreg_high;
      logic [1:0] eoc_sel;
   } charge_cfg_t;

   typedef struct packed {
      logic       supply_ok;
      logic       above_qual;
      logic       at_regulation;
      logic       eoc_cmp_0;
      logic       eoc_cmp_1;
      logic       eoc_cmp_2;
      logic       below_restart;
      logic       temp_ok;
   } sense_t;

endpackage : charge_seq_pkg

// *** test/charge_partner.sv ***
/* charge_partner: usb controller and battery seen through comparators.
   Assumes the bench sets the source, power level and cell voltage. */
`timescale 1ns/10ps
module charge_partner
(
   // bench commands
   input  wire logic        usb_mode,
   input  wire logic        high_power,
   input  wire logic [12:0] batt_mv,
   // from device
   input  wire logic        vreg_high,
   // to device
   output logic             source_is_adaptor,
   output logic             usb_current_level_select,
   output logic             battery_above_qual,
   output logic             battery_at_regulation,
   output logic             battery_below_restart
);
   wire [12:0] term_mv = vreg_high ? 13'h1068 : 13'h1004;
   assign source_is_adaptor        = !usb_mode;
   assign usb_current_level_select = !(usb_mode && high_power);
   assign battery_above_qual       = batt_mv > 13'h0BB8;
   assign battery_at_regulation    = batt_mv >= term_mv;
   assign battery_below_restart    = batt_mv <= term_mv - 13'h00C8;
endmodule : charge_partner

// *** test/li_ion_charge_sequencer_props.sv ***
/* charge_seq_props: phase sequencing checks on the sequencer ports.
   Assumes one clock and synchronous reset. */
`timescale 1ns/10ps
module charge_seq_props
   import charge_seq_pkg::*;
#(
   parameter int TICK_COUNT   = 4,
   parameter int SAFETY_COUNT = 10
)
(
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // pins
   input wire logic       supply_in_limits,
   input wire logic       adaptor_good,
   input wire logic       charger_enable,
   input wire logic       temp_in_range,
   input wire logic       source_is_adaptor,
   input wire logic       usb_current_level_select,
   input wire logic       battery_above_qual,
   input wire logic       battery_at_regulation,
   // outputs
   input wire logic [3:0] charge_current,
   input wire logic       prequal_current,
   input wire logic       charge_on,
   input wire logic       end_of_charge,
   input charge_state_t   phase
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   wire run_ok = supply_in_limits && adaptor_good && charger_enable;
   int  cc_cnt;
   always_ff @(posedge clk)
      cc_cnt <= (phase == ST_CC && !reset) ? cc_cnt + 1 : 0;

   start_gate_a: assert property (
      $past(phase) == ST_OFF && phase == ST_PREQUAL |-> $past(run_ok))
      else $error("prequal without valid supply");
   prequal_cur_a: assert property (
      phase == ST_PREQUAL |-> prequal_current && charge_on)
      else $error("prequal current missing");
   cc_entry_a: assert property (
      $past(phase) == ST_PREQUAL && phase == ST_CC
      |-> $past(battery_above_qual))
      else $error("cc entered below qualification");
   usb_low_a: assert property (
      phase == ST_CC && $past(phase) == ST_CC
      && $past(!source_is_adaptor && usb_current_level_select)
      |-> charge_current == CURRENT_100MA)
      else $error("usb low power current wrong");
   timer_bound_a: assert property (
      cc_cnt <= (SAFETY_COUNT + 2) * TICK_COUNT)
      else $error("safety timer did not end cc");
   cv_entry_a: assert property (
      $past(phase) == ST_CC && phase == ST_CV
      |-> $past(battery_at_regulation))
      else $error("cv entered before regulation");
   maint_flag_a: assert property (
      phase == ST_MAINT |-> end_of_charge && !charge_on)
      else $error("maintenance flags wrong");
   temp_stop_a: assert property (
      $past(!temp_in_range) |-> !charge_on)
      else $error("charging with bad temperature");
   enable_off_a: assert property (
      $past(!charger_enable) |-> phase == ST_OFF)
      else $error("charger on while disabled");
   fault_hold_a: assert property (
      !$past(reset) && $past(phase) == ST_FAULT && phase != ST_FAULT
      |-> $past(!run_ok))
      else $error("fault latch released early");
endmodule : charge_seq_props

bind li_ion_charge_sequencer charge_seq_props #(
   .TICK_COUNT(TICK_COUNT), .SAFETY_COUNT(SAFETY_COUNT))
   charge_seq_props_inst (.clk, .reset, .supply_in_limits, .adaptor_good,
   .charger_enable, .temp_in_range, .source_is_adaptor,
   .usb_current_level_select, .battery_above_qual, .battery_at_regulation,
   .charge_current, .prequal_current, .charge_on, .end_of_charge, .phase);

// *** test/li_ion_charge_sequencer_tb_top.sv ***
/* bench top: drives the sequencer over apb and pins, self-checking.
   Assumes shortened timer parameters and the partner model. */
`timescale 1ns/10ps
module li_ion_charge_sequencer_tb_top;
   import charge_seq_pkg::*;
   localparam int TK = 4;
   localparam int SC = 10;
   logic          clk = 0;
   logic          reset = 1;
   logic          psel = 0;
   logic          penable = 0;
   logic          pwrite = 0;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0;
   logic          supply_in_limits = 0;
   logic          adaptor_good = 0;
   logic          charger_enable = 1;
   logic          temp_in_range = 1;
   logic [2:0]    current_below_eoc = '0;
   logic          usb_mode = 0;
   logic          high_power = 0;
   logic [12:0]   batt_mv = 13'h09C4;
   logic [31:0]   prdata;
   logic          pready, pslverr, source_is_adaptor;
   logic          usb_current_level_select, battery_above_qual;
   logic          battery_at_regulation, battery_below_restart;
   logic [3:0]    charge_current;
   logic          prequal_current, charge_on, vreg_high;
   logic          end_of_charge, fault;
   charge_state_t phase;
   logic [31:0]   exp_q[$];
   int            err_total = 0;
   int            num_checks = 0;
   int            seed = 24891;
   logic [3:0]    code;
   logic          exp_err;

   // unmapped offsets answer with an error in the access phase
   assign exp_err = !(paddr inside {CTRL_OFFSET, CONFIG_OFFSET,
                                    STATUS_OFFSET});

   always #5 clk = ~clk;

   li_ion_charge_sequencer #(.TICK_COUNT(TK), .SAFETY_COUNT(SC))
      li_ion_charge_sequencer_inst (.clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_in_limits,
      .adaptor_good, .source_is_adaptor, .usb_current_level_select,
      .charger_enable, .battery_above_qual, .battery_at_regulation,
      .current_below_eoc, .battery_below_restart, .temp_in_range,
      .charge_current, .prequal_current, .charge_on, .vreg_high,
      .end_of_charge, .fault, .phase);
   charge_partner charge_partner_inst (.usb_mode, .high_power, .batt_mv,
      .vreg_high, .source_is_adaptor, .usb_current_level_select,
      .battery_above_qual, .battery_at_regulation, .battery_below_restart);

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(0, a, '0);
   endtask : rd

   task automatic wait_ph(input charge_state_t p);
      int n;
      n = 0;
      while (phase !== p && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(phase), 32'(p));
   endtask : wait_ph

   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // read result monitor
   // ------------------------------------------------------------
   always @(posedge clk)
      if (psel && penable && pready === 1'b1)
      begin
         chk(32'(pslverr), 32'(exp_err));
         if (!pwrite)
            chk(prdata, exp_q.pop_front());
      end

   initial
   begin
      #20000;
      err_total++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      chk(32'(vreg_high), 32'h1);
      rd(CONFIG_OFFSET, 32'h0000_0018);
      rd(12'h00C, 32'h0);
      rd(STATUS_OFFSET, 32'h0);
      code = 4'(($random(seed) & 3) + 9);
      apb(1, CONFIG_OFFSET, {22'h0, 2'h2, 4'h0, code});
      rd(CONFIG_OFFSET, {22'h0, 2'h2, 4'h0, code});
      chk(32'(vreg_high), 32'h0);
      supply_in_limits <= 1;
      repeat (5) @(posedge clk);
      chk(32'(phase), 32'(ST_OFF));
      adaptor_good <= 1;
      wait_ph(ST_PREQUAL);
      chk(32'(prequal_current), 32'h1);
      batt_mv <= 13'h0C1C;
      wait_ph(ST_CC);
      repeat (2) @(posedge clk);
      chk(32'(charge_current), 32'(code));
      batt_mv <= 13'h1004;
      wait_ph(ST_CV);
      current_below_eoc <= 3'h3;
      repeat (4) @(posedge clk);
      chk(32'(phase), 32'(ST_CV));
      current_below_eoc <= 3'h7;
      wait_ph(ST_MAINT);
      chk(32'(end_of_charge), 32'h1);
      current_below_eoc <= 3'h0;
      batt_mv <= 13'h0F3C;
      wait_ph(ST_PREQUAL);
      temp_in_range <= 0;
      wait_ph(ST_TEMP);
      chk(32'(charge_on), 32'h0);
      chk(32'(fault), 32'h1);
      temp_in_range <= 1;
      batt_mv <= 13'h09C4;
      wait_ph(ST_PREQUAL);
      charger_enable <= 0;
      wait_ph(ST_OFF);
      charger_enable <= 1;
      usb_mode <= 1;
      batt_mv <= 13'h0C1C;
      wait_ph(ST_CC);
      repeat (2) @(posedge clk);
      chk(32'(charge_current), 32'(CURRENT_100MA));
      high_power <= 1;
      repeat (3) @(posedge clk);
      chk(32'(charge_current), 32'(code));
      wait_ph(ST_FAULT);
      temp_in_range <= 0;
      repeat (4) @(posedge clk);
      chk(32'(phase), 32'(ST_FAULT));
      chk(32'(fault), 32'h1);
      rd(STATUS_OFFSET, 32'h0000_00A5);
      apb(1, CTRL_OFFSET, 32'h0000_0001);
      rd(STATUS_OFFSET, 32'h0000_0025);
      supply_in_limits <= 0;
      wait_ph(ST_OFF);
      end_of_test();
   end
endmodule : li_ion_charge_sequencer_tb_top
